// *** rtl/acq_regs.svh ***
`ifndef ACQ_REGS_SVH
`define ACQ_REGS_SVH
// Byte addresses of the register words on the AHB-Lite port.
`define ACQ_PARTITION_ADDR  16'h800c
`define ACQ_RELEASE_ADDR    16'h8010
`define ACQ_RELEASE_STS_ADDR 16'h8018
`define ACQ_EVLEN_ADDR      16'h8020
`define ACQ_CONTROL_ADDR    16'h8100
`define ACQ_STATUS_ADDR     16'h8104
`define ACQ_SWTRIG_ADDR     16'h8108
`define ACQ_TRIGMASK_ADDR   16'h810c
// Field positions.
`define ACQ_CTL_COUNT_ALL   3
`define ACQ_CTL_RUN         2
`define ACQ_STS_READY       8
`define ACQ_STS_PLL         7
`define ACQ_STS_BYPASS      6
`define ACQ_STS_CLKEXT      5
`define ACQ_STS_FULL        4
`define ACQ_STS_EVREADY     3
`define ACQ_STS_RUN         2
`define ACQ_MSK_SW          31
`define ACQ_MSK_EXT         30
`define ACQ_MSK_LVL_HI      26
`define ACQ_MSK_LVL_LO      24
// Largest partition code and reset values.
`define ACQ_PART_MAX        4'ha
`define ACQ_PART_RST        4'h0
`define ACQ_CTL_RST         4'h0
`define ACQ_MSK_RST         32'h0000_0000
`endif

// *** rtl/acq_pkg.sv ***
package acq_pkg;
   // Run-mode field, in field-value order 00, 01, 10, 11.
   typedef enum logic [1:0] {
      mode_reg_run, mode_sync_run, mode_sync_gate, mode_multi_sync
   } run_mode_e;
   // Acquisition run state.
   typedef enum logic {st_stopped, st_running} run_state_e;
   // Board conditions reported in the status word.
   typedef struct packed {
      logic board_ready;  // PLL and ADCs synchronised.
      logic pll_locked;   // PLL lock level.
      logic pll_bypass;   // PLL bypassed.
      logic clk_external; // External clock selected.
      logic event_full;   // Event store at its limit.
      logic event_ready;  // At least one event stored.
   } board_state_s;
   // One-cycle commands to the acquisition core.
   typedef struct packed {
      logic soft_clear;   // Clear acquisition logic.
      logic memory_reset; // Reset the event memory.
      logic trigger;      // One accepted trigger.
      logic release_req;  // Free blocks, count beside it.
   } acq_pulse_s;
endpackage

// *** rtl/acq_ctrl.sv ***
`timescale 1ns/1ps
`include "acq_regs.svh"
// Function
// - Partition code splits memory into 2^code blocks
// - Partition write also issues a software clear
// - Release write frees first N blocks
// - Zero event length disables custom length
// - Control bit 3 picks trigger counting
// - Setting run bit starts run, resets memory
// - Clearing run bit stops, keeps stored data
// - Stopped board ignores all triggers
// - Mode 00: run bit control, gate open
// - Mode 01: sync input starts run, gate open
// - Mode 10: sync input is the gate
// - Mode 11: sync input only synchronises
// - Status bit 8 shows board ready
// - Status bit 7 latches lock loss until read
// - Status bits 4,3: events full, ready
// - Any software trigger write makes one trigger
// - Mask bits 7:0 enable channel local triggers
// - Local trigger needs bits 26:24 other channels over threshold
// - Mask bits 30,31 enable external, software triggers
// - Over-release sets a release error flag
module acq_ctrl
   import acq_pkg::*;
#(
   parameter int NCHAN = 8 // Channel count.
)(
   input  wire logic               hclk,          // Bus clock.
   input  wire logic               hresetn,       // Async reset.
   input  wire logic               hsel,          // Slave select.
   input  wire logic [15:0]        haddr,         // Byte address.
   input  wire logic [1:0]         htrans,        // Transfer type.
   input  wire logic               hwrite,        // Write flag.
   input  wire logic [2:0]         hsize,         // Word only.
   input  wire logic [31:0]        hwdata,        // Write data.
   input  wire logic               hready,        // Bus ready.
   output logic                    hreadyout,     // Always ready.
   output logic [31:0]             hrdata,        // Read data.
   output logic                    hresp,         // Always OKAY.
   input  wire logic [NCHAN-1:0]   chan_over_thr, // Over threshold.
   input  wire logic               external_trigger_input, // Level.
   input  wire logic               sync_in,       // Sync input.
   input  wire acq_pkg::board_state_s board,      // Board state.
   input  wire logic [10:0]        occupied_blocks, // Used blocks.
   output acq_pkg::acq_pulse_s     pulse,         // Commands.
   output logic [11:0]             release_count, // Blocks to free.
   output logic [3:0]              partition_code, // Block code.
   output logic [10:0]             block_count,   // 2^code blocks.
   output logic [31:0]             event_location_count, // Length.
   output logic                    custom_len_en, // Length in use.
   output logic                    count_all_trig, // Count mode.
   output logic                    gate_open,     // Acq gate.
   output logic                    sync_enable,   // Multiboard sync.
   output logic                    run_on         // Running.
);
   import acq_pkg::*;

   // Blocks for a partition code; codes above the top saturate.
   function automatic logic [10:0] blocks_of(input logic [3:0] c);
      logic [3:0] k;
      k = (c > `ACQ_PART_MAX) ? `ACQ_PART_MAX : c;
      return 11'h001 << k;
   endfunction

   // Number of ones in a channel vector.
   function automatic logic [3:0] ones(input logic [NCHAN-1:0] v);
      logic [3:0] s;
      s = 4'h0;
      for (int i = 0; i < NCHAN; i++) begin
         s = s + {3'h0, v[i]};
      end
      return s;
   endfunction

   logic        wr_pend;       // Write data phase pending.
   logic [15:0] wr_addr;       // Address of that write.
   logic        take;          // Address phase accepted.
   logic        st_read;       // Status word read this phase.
   logic [31:0] next_rdata;    // Read word for next cycle.
   logic [1:0]  mode;          // Run-mode field.
   logic        sw_en;         // Software trigger source on.
   logic        ext_en;        // External trigger source on.
   logic [2:0]  coin_lvl;      // Coincidence level.
   logic [NCHAN-1:0] chan_en;  // Channel trigger enables.
   logic        pll_flag;      // Sticky lock flag, 1 = no loss.
   logic        release_err;   // Sticky over-release flag.
   logic        sync_q;        // Sync input one cycle ago.
   logic        ext_q;         // External trigger one cycle ago.
   logic [NCHAN-1:0] chan_q;   // Threshold state one cycle ago.
   logic        local_hit;     // Qualified local trigger.
   logic        wr_part;       // Partition word written.
   logic        wr_rel;        // Release word written.
   logic        wr_ctl;        // Control word written.
   logic        wr_sw;         // Software trigger written.
   logic        next_run;      // Run state after this edge.
   run_state_e  run_state;     // Acquisition state.

   assign take    = hsel & htrans[1] & hready;
   assign st_read = take & ~hwrite & (haddr == `ACQ_STATUS_ADDR);
   assign wr_part = wr_pend & (wr_addr == `ACQ_PARTITION_ADDR);
   assign wr_rel  = wr_pend & (wr_addr == `ACQ_RELEASE_ADDR);
   assign wr_ctl  = wr_pend & (wr_addr == `ACQ_CONTROL_ADDR);
   assign wr_sw   = wr_pend & (wr_addr == `ACQ_SWTRIG_ADDR);

   // The slave never inserts wait states and never errors, so the
   // master's data phase always completes on the next edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Capture each accepted write so its data can be taken next cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 16'h0000;
      end else begin
         wr_pend <= take & hwrite;
         wr_addr <= haddr;
      end
   end

   // Read word, built in the address phase; unmapped reads give zero.
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr)
         `ACQ_PARTITION_ADDR: next_rdata[3:0] = partition_code;
         `ACQ_RELEASE_ADDR:   next_rdata[11:0] = release_count;
         `ACQ_RELEASE_STS_ADDR: next_rdata[0] = release_err;
         `ACQ_EVLEN_ADDR:     next_rdata = event_location_count;
         `ACQ_CONTROL_ADDR:   next_rdata[3:0] =
            {count_all_trig, run_on, mode};
         `ACQ_STATUS_ADDR: begin
            next_rdata[`ACQ_STS_READY]   = board.board_ready;
            next_rdata[`ACQ_STS_PLL]     = pll_flag;
            next_rdata[`ACQ_STS_BYPASS]  = board.pll_bypass;
            next_rdata[`ACQ_STS_CLKEXT]  = board.clk_external;
            next_rdata[`ACQ_STS_FULL]    = board.event_full;
            next_rdata[`ACQ_STS_EVREADY] = board.event_ready;
            next_rdata[`ACQ_STS_RUN]     = run_on;
         end
         `ACQ_TRIGMASK_ADDR: begin
            next_rdata[`ACQ_MSK_SW]  = sw_en;
            next_rdata[`ACQ_MSK_EXT] = ext_en;
            next_rdata[`ACQ_MSK_LVL_HI:`ACQ_MSK_LVL_LO] = coin_lvl;
            next_rdata[NCHAN-1:0] = chan_en;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is registered; a read right after a write to the same
   // word still sees the old value, traded for a flop-driven hrdata.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take & ~hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // Partition code and its block count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         partition_code <= `ACQ_PART_RST;
         block_count    <= 11'h001;
      end else if (wr_part) begin
         partition_code <= hwdata[3:0];
         block_count    <= blocks_of(hwdata[3:0]);
      end
   end

   // Custom event length; zero turns the custom length off.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_location_count <= 32'h0000_0000;
         custom_len_en        <= 1'b0;
      end else if (wr_pend & (wr_addr == `ACQ_EVLEN_ADDR)) begin
         event_location_count <= hwdata;
         custom_len_en        <= (hwdata != 32'h0000_0000);
      end
   end

   // Control fields other than the run bit.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_all_trig <= 1'b0;
         mode           <= 2'h0;
      end else if (wr_ctl) begin
         count_all_trig <= hwdata[`ACQ_CTL_COUNT_ALL];
         mode           <= hwdata[1:0];
      end
   end

   // Trigger source mask.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_en    <= 1'b0;
         ext_en   <= 1'b0;
         coin_lvl <= 3'h0;
         chan_en  <= '0;
      end else if (wr_pend & (wr_addr == `ACQ_TRIGMASK_ADDR)) begin
         sw_en    <= hwdata[`ACQ_MSK_SW];
         ext_en   <= hwdata[`ACQ_MSK_EXT];
         coin_lvl <= hwdata[`ACQ_MSK_LVL_HI:`ACQ_MSK_LVL_LO];
         chan_en  <= hwdata[NCHAN-1:0];
      end
   end

   // Run state: the run bit starts and stops; in mode 01 a sync edge
   // also starts the run. Stopping touches no stored data.
   always_comb begin
      next_run = (run_state == st_running);
      case (run_state)
         st_stopped: begin
            if (wr_ctl & hwdata[`ACQ_CTL_RUN]) begin
               next_run = 1'b1;
            end else if (mode == 2'(mode_sync_run) & sync_in & ~sync_q) begin
               next_run = 1'b1;
            end
         end
         st_running: begin
            if (wr_ctl & ~hwdata[`ACQ_CTL_RUN]) begin
               next_run = 1'b0;
            end
         end
         default: next_run = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_state <= st_stopped;
         run_on    <= 1'b0;
      end else begin
         run_state <= next_run ? st_running : st_stopped;
         run_on    <= next_run;
      end
   end

   // Gate and sync use follow the run-mode field.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_open   <= 1'b1;
         sync_enable <= 1'b1;
      end else begin
         gate_open   <= (mode != 2'(mode_sync_gate)) | sync_in;
         sync_enable <= (mode != 2'(mode_sync_gate));
      end
   end

   // Previous input levels, for edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_q <= 1'b0;
         ext_q  <= 1'b0;
         chan_q <= '0;
      end else begin
         sync_q <= sync_in;
         ext_q  <= external_trigger_input;
         chan_q <= chan_over_thr;
      end
   end

   // A newly crossing enabled channel triggers only when enough of the
   // other channels are over threshold in the same cycle.
   always_comb begin
      local_hit = 1'b0;
      for (int n = 0; n < NCHAN; n++) begin
         if (chan_en[n] & chan_over_thr[n] & ~chan_q[n] &
             (ones(chan_over_thr & ~(NCHAN'(1) << n)) >=
              {1'b0, coin_lvl})) begin
            local_hit = 1'b1;
         end
      end
   end

   // Command pulses; triggers pass only while running and gated.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse         <= '0;
         release_count <= 12'h000;
      end else begin
         pulse.soft_clear   <= wr_part;
         pulse.memory_reset <= next_run &
            (run_state == st_stopped);
         pulse.trigger      <= run_on & gate_open &
            (local_hit | (ext_en & external_trigger_input & ~ext_q) |
             (sw_en & wr_sw));
         pulse.release_req  <= wr_rel;
         if (wr_rel) begin
            release_count <= hwdata[11:0];
         end
      end
   end

   // Sticky flags: a loss of lock beats a restoring read; a new
   // over-release beats the clearing read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_flag    <= 1'b1;
         release_err <= 1'b0;
      end else begin
         if (!board.pll_locked) begin
            pll_flag <= 1'b0;
         end else if (st_read) begin
            pll_flag <= 1'b1;
         end
         if (wr_rel & ({1'b0, occupied_blocks} < hwdata[11:0])) begin
            release_err <= 1'b1;
         end else if (take & ~hwrite &
                      (haddr == `ACQ_RELEASE_STS_ADDR)) begin
            release_err <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence part_write;
      take & hwrite & (haddr == `ACQ_PARTITION_ADDR);
   endsequence
   sequence over_release;
      wr_rel & ({1'b0, occupied_blocks} < hwdata[11:0]);
   endsequence

   soft_clear_a: assert property (
      part_write ##1 1'b1 |=> pulse.soft_clear)
      else $error("partition write gave no soft clear");
   run_reset_a: assert property (
      $rose(run_on) |-> pulse.memory_reset)
      else $error("run start without memory reset");
   stopped_trig_a: assert property (
      pulse.trigger |-> $past(run_on))
      else $error("trigger while stopped");
   rel_err_a: assert property (
      over_release |=> release_err)
      else $error("over-release not flagged");
   pll_loss_a: assert property (
      !board.pll_locked |=> !pll_flag[*2] or board.pll_locked)
      else $error("lock loss not held");
   gate_mode_a: assert property (
      mode == 2'(mode_sync_gate) |=> gate_open == $past(sync_in))
      else $error("gate does not follow sync");
   sw_trig_a: assert property (
      run_on & gate_open & sw_en & wr_sw |=> pulse.trigger)
      else $error("software trigger lost");
   blocks_a: assert property (
      wr_part & (hwdata[3:0] <= `ACQ_PART_MAX) |=>
      block_count == (11'h001 << partition_code))
      else $error("block count wrong");
endmodule

// *** tb/tb_digitizer_acquisition_control_regs.sv ***
`timescale 1ns/1ps
`include "acq_regs.svh"
// Self-checking bench for the acquisition control registers.
module tb_digitizer_acquisition_control_regs;
   import acq_pkg::*;
   logic              hclk;                 // Bus clock, 200 MHz.
   logic              hresetn;              // Async reset, active low.
   logic              hsel;                 // Slave select.
   logic [15:0]       haddr;                // Byte address.
   logic [1:0]        htrans;               // Transfer type.
   logic              hwrite;               // Write flag.
   logic [2:0]        hsize;                // Always a word.
   logic [31:0]       hwdata;               // Write data.
   logic              hreadyout;            // Slave ready, is hready.
   logic [31:0]       hrdata;               // Read data.
   logic              hresp;                // Response.
   logic [7:0]        chan_over_thr;        // Channel levels.
   logic              ext_trig;             // External trigger level.
   logic              sync_in;              // Sync input level.
   board_state_s      board;                // Board conditions.
   logic [10:0]       occupied_blocks;      // Blocks in use.
   acq_pulse_s        pulse;                // One-cycle commands.
   logic [11:0]       release_count;        // Last release count.
   logic [3:0]        partition_code;       // Partition code.
   logic [10:0]       block_count;          // Blocks in memory.
   logic [31:0]       event_location_count; // Custom length.
   logic              custom_len_en;        // Custom length in use.
   logic              count_all_trig;       // Counting mode.
   logic              gate_open;            // Acquisition gate.
   logic              sync_enable;          // Multiboard sync.
   logic              run_on;               // Running.
   logic [31:0]       rd_data;              // Discarded read data.
   int                failures = 0;         // Mismatches.
   int                compares = 0;         // Comparisons made.
   int                cycles   = 0;         // Watchdog count.

   acq_ctrl #(.NCHAN(8)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .chan_over_thr(chan_over_thr),
      .external_trigger_input(ext_trig), .sync_in(sync_in),
      .board(board), .occupied_blocks(occupied_blocks), .pulse(pulse),
      .release_count(release_count), .partition_code(partition_code),
      .block_count(block_count),
      .event_location_count(event_location_count),
      .custom_len_en(custom_len_en), .count_all_trig(count_all_trig),
      .gate_open(gate_open), .sync_enable(sync_enable), .run_on(run_on));

   // Free-running clock, 5 ns period.
   initial hclk = 1'b0;
   always #2.5 hclk = ~hclk;

   // Prints the counts and the verdict, then stops the run.
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hang would otherwise go unreported; the sequence needs ~220.
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         conclude();
      end
   end

   // Compares one value with its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // Address phase, held until hready is sampled high.
   task automatic bus_addr(input logic [15:0] a, input logic w);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
   endtask

   // Single word write; returns at the edge closing the data phase.
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus_addr(a, 1'b1);
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   // Single word read; data taken at the edge closing the data phase.
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      bus_addr(a, 1'b0);
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask

   // Reads a register and compares it.
   task automatic rdc(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      check(d, e);
   endtask

   // Drives the trigger inputs, then checks the pulse one cycle later.
   task automatic drive_in(input logic [7:0] ch, input logic ex,
                           input logic [3:0] e);
      @(posedge hclk);
      chan_over_thr <= ch;
      ext_trig <= ex;
      @(posedge hclk);
      #1;
      check({28'h0, pulse}, {28'h0, e});
   endtask

   // Main sequence: each block of calls exercises one feature.
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 16'h0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      chan_over_thr = 8'h00;
      ext_trig = 1'b0;
      sync_in = 1'b0;
      board = 6'h3f;
      occupied_blocks = 11'h003;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      check(block_count, 32'h1);
      check({gate_open, sync_enable, run_on}, 32'h6);
      check({hreadyout, hresp}, 32'h2);
      rdc(`ACQ_CONTROL_ADDR, 32'h0);
      rdc(`ACQ_TRIGMASK_ADDR, 32'h0);
      // Every partition code; upper bits written as ones must read zero.
      for (int c = 0; c <= 10; c++) begin
         wr(`ACQ_PARTITION_ADDR, 32'hffff_fff0 | c);
         #1;
         check({28'h0, pulse}, 32'h8);
         check(block_count, 32'h1 << c);
         rdc(`ACQ_PARTITION_ADDR, c);
      end
      // Releasing more blocks than occupied flags an error.
      wr(`ACQ_RELEASE_ADDR, 32'h0000_f005);
      #1;
      check({28'h0, pulse}, 32'h1);
      check(release_count, 32'h5);
      rdc(`ACQ_RELEASE_STS_ADDR, 32'h1);
      rdc(`ACQ_RELEASE_STS_ADDR, 32'h0);
      wr(`ACQ_RELEASE_ADDR, 32'h0000_0002);
      #1;
      check(release_count, 32'h2);
      rdc(`ACQ_RELEASE_STS_ADDR, 32'h0);
      // Custom length off at zero, on at any other value.
      wr(`ACQ_EVLEN_ADDR, 32'h0);
      #1;
      check(custom_len_en, 32'h0);
      wr(`ACQ_EVLEN_ADDR, 32'h8000_0123);
      #1;
      check(custom_len_en, 32'h1);
      check(event_location_count, 32'h8000_0123);
      wr(16'h8200, 32'hffff_ffff);
      rdc(16'h8200, 32'h0);
      // Stopped board ignores an enabled software trigger.
      wr(`ACQ_TRIGMASK_ADDR, 32'hffff_ffff);
      rdc(`ACQ_TRIGMASK_ADDR, 32'hc700_00ff);
      wr(`ACQ_CONTROL_ADDR, 32'h8);
      #1;
      check({count_all_trig, run_on}, 32'h2);
      wr(`ACQ_SWTRIG_ADDR, 32'h0);
      #1;
      check({28'h0, pulse}, 32'h0);
      // Run start resets memory; status shows the run.
      wr(`ACQ_CONTROL_ADDR, 32'hc);
      #1;
      check({27'h0, run_on, pulse}, 32'h14);
      rdc(`ACQ_CONTROL_ADDR, 32'hc);
      rd(`ACQ_STATUS_ADDR, rd_data);
      rdc(`ACQ_STATUS_ADDR, 32'h1fc);
      wr(`ACQ_SWTRIG_ADDR, 32'h1234_5678);
      #1;
      check({28'h0, pulse}, 32'h2);
      drive_in(8'h00, 1'b1, 4'h2);
      wr(`ACQ_TRIGMASK_ADDR, 32'h4000_0000);
      wr(`ACQ_SWTRIG_ADDR, 32'h0);
      #1;
      check({28'h0, pulse}, 32'h0);
      drive_in(8'h00, 1'b0, 4'h0);
      wr(`ACQ_TRIGMASK_ADDR, 32'h8000_0000);
      drive_in(8'h00, 1'b1, 4'h0);
      // Level 1 with two channels enabled, below the enabled count.
      wr(`ACQ_TRIGMASK_ADDR, 32'h0100_0003);
      drive_in(8'h01, 1'b0, 4'h0);
      drive_in(8'h02, 1'b0, 4'h0);
      drive_in(8'h03, 1'b0, 4'h2);
      drive_in(8'h80, 1'b0, 4'h0);
      wr(`ACQ_TRIGMASK_ADDR, 32'h0000_0004);
      drive_in(8'h84, 1'b0, 4'h2);
      // Stop keeps data: no clear or reset, triggers ignored.
      wr(`ACQ_TRIGMASK_ADDR, 32'h4000_0000);
      wr(`ACQ_CONTROL_ADDR, 32'h8);
      #1;
      check({27'h0, run_on, pulse}, 32'h0);
      drive_in(8'h00, 1'b0, 4'h0);
      drive_in(8'h00, 1'b1, 4'h0);
      // Run modes and the sync input; inputs move only on an edge.
      wr(`ACQ_CONTROL_ADDR, 32'h0);
      @(posedge hclk);
      sync_in <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      check({gate_open, sync_enable, run_on}, 32'h6);
      @(posedge hclk);
      sync_in <= 1'b0;
      wr(`ACQ_CONTROL_ADDR, 32'h1);
      @(posedge hclk);
      sync_in <= 1'b1;
      @(posedge hclk);
      #1;
      check({gate_open, run_on, pulse}, 32'h34);
      wr(`ACQ_CONTROL_ADDR, 32'h2);
      @(posedge hclk);
      sync_in <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      check({gate_open, sync_enable}, 32'h0);
      @(posedge hclk);
      sync_in <= 1'b1;
      @(posedge hclk);
      #1;
      check(gate_open, 32'h1);
      wr(`ACQ_TRIGMASK_ADDR, 32'h8000_0000);
      wr(`ACQ_CONTROL_ADDR, 32'h6);
      wr(`ACQ_SWTRIG_ADDR, 32'h0);
      #1;
      check({28'h0, pulse}, 32'h2);
      @(posedge hclk);
      sync_in <= 1'b0;
      wr(`ACQ_SWTRIG_ADDR, 32'h0);
      #1;
      check({28'h0, pulse}, 32'h0);
      // Sync use follows the stored mode one cycle after the write.
      wr(`ACQ_CONTROL_ADDR, 32'h3);
      @(posedge hclk);
      #1;
      check({sync_enable, run_on}, 32'h2);
      // Lock loss stays latched until a status read after relock.
      @(posedge hclk);
      board <= 6'h2a;
      @(posedge hclk);
      board <= 6'h3a;
      rdc(`ACQ_STATUS_ADDR, 32'h150);
      rdc(`ACQ_STATUS_ADDR, 32'h1d0);
      board <= 6'h15;
      rdc(`ACQ_STATUS_ADDR, 32'h0a8);
      conclude();
   end
endmodule
